// ==== rtl/lpddr2_pin_cfg.svh ====
// Constants of the LPDDR2 pin interface: widths, encodings and timing counts.
// Assumes a 40 MHz sampling clock and a link clock of 200 ns period.
`ifndef LPDDR2_PIN_CFG_SVH
`define LPDDR2_PIN_CFG_SVH

`define CA_W 10
`define DQ_W 32
`define LANES 4
`define BA_W 3
`define ROW_W 14
`define COL_W 10
`define DS_W 4
`define DS_34R3 4'h1
`define CLK_NS 25
`define LINK_HALF_NS 100
`define BEAT_CYC ((`LINK_HALF_NS) / (`CLK_NS))
`define BEAT_CNT_W 3
`define FIFO_DEPTH 16

`endif

// ==== rtl/lpddr2_pin_pkg.sv ====
// Types shared by the LPDDR2 pin interface and its write-data FIFO.
// Assumes the constants header is on the include path.
`include "lpddr2_pin_cfg.svh"

package lpddr2_pin_pkg;

  typedef struct packed {
    logic cke_prev;
    logic cke;
    logic cs_n;
    logic [`CA_W-1:0] ca_rise;
    logic [`CA_W-1:0] ca_fall;
  } cmd_t;

  typedef struct packed {
    logic [`BA_W-1:0] bank;
    logic [`ROW_W-1:0] row;
    logic [`COL_W-1:0] col;
  } addr_t;

  typedef struct packed {
    logic [`LANES-1:0] byte_en;
    logic [`DQ_W-1:0] data;
  } wr_beat_t;

  typedef struct packed {
    logic ck_t;
    logic ck_c;
    logic cke;
    logic cs_n;
    logic [`CA_W-1:0] ca;
    logic [`DQ_W-1:0] dq;
    logic [`LANES-1:0] dqs_t;
    logic [`LANES-1:0] dqs_c;
    logic [`LANES-1:0] dm;
  } pins_t;

  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_PRE = 3'b010,
    RD_BEAT = 3'b100
  } rd_state_t;

endpackage : lpddr2_pin_pkg

// ==== rtl/stream_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; both sides share clk and srst.
`timescale 1ns/1ps

module stream_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk, // Sampling clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [W-1:0] in_data, // Word in.
  output logic out_valid, // Word available.
  input wire logic out_ready, // Consumer takes the word.
  output logic [W-1:0] out_data // Oldest word.
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = count_q != (AW+1)'(DEPTH);
  assign out_valid = count_q != '0;
  assign out_data = mem[rd_ptr_q];

  always_comb
  begin
    count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q <= count_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_q] <= in_data;
    end
  end

endmodule : stream_fifo

// ==== rtl/lpddr2_pin_if.sv ====
// Device-side pin logic of one x32 LPDDR2 die: CA capture, CKE power
// state, strobe-timed write capture into a FIFO and edge-aligned read drive.
// Assumes all pins are asynchronous to clk and the link clock is slower
// than clk by at least a factor of four.
//
// Overview of operation
// - CA bus captured on both positive and negative link clock edges.
// - Chip select and CKE sampled only on the positive link edge.
// - Positive edge is true rising with complement falling; negative is reverse.
// - CKE high runs clocks, input buffers and drivers; low stops them all.
// - Power-saving entry and exit are recognised from CKE transitions.
// - CKE, chip select and CA together form one command code.
// - CA bus is input only; the device never drives it.
// - Device drives strobe with read data and receives it on writes.
// - Read data edges launched aligned with strobe edges.
// - Strobe pair 0 times bits 0-7, pair 1 times bits 8-15.
// - Column bits 0-9 used; bit 0 not sent and always zero.
// - Unused row and column positions on the CA bus are ignored.
// - Mask pins are inputs only and never carry read data.
// - Drive-strength code 0001B selects 34.3 ohm output drive.
// - Mask sampled on both strobe edges; masked bytes are discarded.
// - Mask 0 covers bits 0-7, each next mask the next byte lane.
`timescale 1ns/1ps

module lpddr2_pin_if
  import lpddr2_pin_pkg::*;
(
  input wire logic clk, // 40 MHz sampling clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic ck_t, // Link clock, true.
  input wire logic ck_c, // Link clock, complement.
  input wire logic cke, // Clock enable pin.
  input wire logic cs_n, // Chip select pin, active low.
  input wire logic [`CA_W-1:0] ca, // Command/address pins.
  input wire logic [`DQ_W-1:0] dq_i, // Data pins, received level.
  output logic [`DQ_W-1:0] dq_o, // Data pins, driven level.
  output logic [`DQ_W-1:0] dq_oe, // Data pins, drive enable.
  input wire logic [`LANES-1:0] dqs_t_i, // Strobe true, received.
  input wire logic [`LANES-1:0] dqs_c_i, // Strobe complement, received.
  output logic [`LANES-1:0] dqs_t_o, // Strobe true, driven.
  output logic [`LANES-1:0] dqs_c_o, // Strobe complement, driven.
  output logic [`LANES-1:0] dqs_oe, // Strobe drive enable.
  input wire logic [`LANES-1:0] dm, // Write mask pins.
  output logic cmd_valid_q, // One-cycle pulse per command.
  output cmd_t cmd_q, // Command code.
  output addr_t addr_q, // Address fields of the command.
  output logic clk_run_q, // Internal clocks running.
  output logic pwr_save_q, // Power-saving mode active.
  input wire logic wr_en, // Core expects a write burst.
  output logic wr_valid, // Write beat available.
  input wire logic wr_ready, // Core takes the write beat.
  output wr_beat_t wr_beat, // Write beat with byte enables.
  output logic wr_overflow_q, // Sticky: beat lost on full FIFO.
  input wire logic rd_en, // Core has a read burst to send.
  input wire logic rd_valid, // Read beat offered.
  output logic rd_ready_q, // Read beat taken when valid too.
  input wire logic [`DQ_W-1:0] rd_data, // Read beat.
  input wire logic [`DS_W-1:0] ds_code, // Drive-strength field.
  output logic ds_34r3_q // 34.3 ohm drive selected.
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------

  function automatic logic [1:0] diff_edge(input logic t, input logic c,
                                            input logic tp, input logic cp);
    diff_edge = {t & ~c & ~tp & cp, ~t & c & tp & ~cp};
  endfunction : diff_edge

  pins_t s1_q;
  pins_t s2_q;
  logic ck_t_p_q;
  logic ck_c_p_q;
  logic [`LANES-1:0] dqs_t_p_q;
  logic [`LANES-1:0] dqs_c_p_q;

  wire pins_t pin_now = '{ck_t, ck_c, cke, cs_n, ca, dq_i, dqs_t_i, dqs_c_i, dm};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      ck_t_p_q <= 1'b0;
      ck_c_p_q <= 1'b0;
      dqs_t_p_q <= '0;
      dqs_c_p_q <= '0;
    end
    else
    begin
      s1_q <= pin_now;
      s2_q <= s1_q;
      ck_t_p_q <= s2_q.ck_t;
      ck_c_p_q <= s2_q.ck_c;
      dqs_t_p_q <= s2_q.dqs_t;
      dqs_c_p_q <= s2_q.dqs_c;
    end
  end

  wire [1:0] ck_edge = diff_edge(s2_q.ck_t, s2_q.ck_c, ck_t_p_q, ck_c_p_q);
  wire ck_pos = ck_edge[1];
  wire ck_neg = ck_edge[0];

  // ----------------------------------------------------------------------
  // Command capture and power state
  // ----------------------------------------------------------------------

  logic cke_prev_q;
  logic cs_n_q;
  logic [`CA_W-1:0] ca_rise_q;

  wire cke_enter = clk_run_q & ~s2_q.cke;
  wire cke_exit = ~clk_run_q & s2_q.cke;
  wire cmd_emit = ck_neg & (clk_run_q | cke_prev_q);
  wire cmd_t cmd_now = '{cke_prev_q, clk_run_q, cs_n_q, ca_rise_q, s2_q.ca};

  function automatic addr_t addr_of(input cmd_t c);
    addr_of.bank = c.ca_rise[9:7];
    addr_of.row = {c.ca_fall[9:0], c.ca_rise[6:3]};
    addr_of.col = {c.ca_fall[9:1], 1'b0};
  endfunction : addr_of

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      clk_run_q <= 1'b0;
      cke_prev_q <= 1'b0;
      cs_n_q <= 1'b1;
      ca_rise_q <= '0;
      pwr_save_q <= 1'b0;
    end
    else if (ck_pos)
    begin
      cke_prev_q <= clk_run_q;
      clk_run_q <= s2_q.cke;
      cs_n_q <= s2_q.cs_n;
      ca_rise_q <= s2_q.ca;
      pwr_save_q <= cke_enter | (pwr_save_q & ~cke_exit);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_valid_q <= 1'b0;
      cmd_q <= '0;
      addr_q <= '0;
    end
    else
    begin
      cmd_valid_q <= cmd_emit;
      if (cmd_emit)
      begin
        cmd_q <= cmd_now;
        addr_q <= addr_of(cmd_now);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write capture, one byte lane per strobe pair
  // ----------------------------------------------------------------------

  logic [`LANES-1:0] dqs_rise;
  logic [`LANES-1:0] dqs_fall;
  logic [`LANES-1:0] keep_q;
  logic [`DQ_W-1:0] byte_q;
  logic wr_push_q;
  logic oe_q;
  logic fifo_ready;
  wire wr_open = wr_en & clk_run_q & ~oe_q;

  for (genvar i = 0; i < `LANES; i++)
  begin : g_lane
    assign {dqs_rise[i], dqs_fall[i]} =
        diff_edge(s2_q.dqs_t[i], s2_q.dqs_c[i], dqs_t_p_q[i], dqs_c_p_q[i]);
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        byte_q[8*i +: 8] <= '0;
        keep_q[i] <= 1'b0;
      end
      else if (wr_open & (dqs_rise[i] | dqs_fall[i]))
      begin
        byte_q[8*i +: 8] <= s2_q.dq[8*i +: 8];
        keep_q[i] <= ~s2_q.dm[i];
      end
    end
  end

  wire lane_edge = wr_open & |(dqs_rise | dqs_fall);
  wire wr_beat_t beat_in = '{keep_q, byte_q};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_push_q <= 1'b0;
      wr_overflow_q <= 1'b0;
    end
    else
    begin
      wr_push_q <= lane_edge;
      wr_overflow_q <= wr_overflow_q | (wr_push_q & ~fifo_ready);
    end
  end

  stream_fifo #(
    .W($bits(wr_beat_t)),
    .DEPTH(`FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(wr_push_q),
    .in_ready(fifo_ready),
    .in_data(beat_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_beat)
  );

  // ----------------------------------------------------------------------
  // Read drive: strobe toggles in the same cycle as each data beat
  // ----------------------------------------------------------------------

  rd_state_t rd_state_q;
  rd_state_t rd_state_d;
  logic [`BEAT_CNT_W-1:0] cnt_q;
  logic [`BEAT_CNT_W-1:0] cnt_d;
  logic [`DQ_W-1:0] dq_q;
  logic dqs_q;
  logic oe_d;

  localparam logic [`BEAT_CNT_W-1:0] BEAT_LAST = `BEAT_CNT_W'(`BEAT_CYC - 1);
  wire cnt_end = cnt_q == '0;
  wire take = rd_valid & rd_ready_q;
  wire ready_d = (rd_state_q != RD_IDLE) & (cnt_q == `BEAT_CNT_W'(1)) & clk_run_q;

  always_comb
  begin
    rd_state_d = rd_state_q;
    cnt_d = cnt_end ? BEAT_LAST : cnt_q - `BEAT_CNT_W'(1);
    oe_d = oe_q;
    case (rd_state_q)
      RD_IDLE:
      begin
        cnt_d = BEAT_LAST;
        if (rd_en & clk_run_q)
        begin
          rd_state_d = RD_PRE;
          oe_d = 1'b1;
        end
      end
      RD_PRE, RD_BEAT:
      begin
        if (cnt_end)
        begin
          rd_state_d = take ? RD_BEAT : RD_IDLE;
          oe_d = take;
        end
      end
      default:
      begin
        rd_state_d = RD_IDLE;
        oe_d = 1'b0;
      end
    endcase
    if (!clk_run_q)
    begin
      rd_state_d = RD_IDLE;
      oe_d = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rd_state_q <= RD_IDLE;
      cnt_q <= '0;
      oe_q <= 1'b0;
      rd_ready_q <= 1'b0;
      dq_q <= '0;
      dqs_q <= 1'b0;
    end
    else
    begin
      rd_state_q <= rd_state_d;
      cnt_q <= cnt_d;
      oe_q <= oe_d;
      rd_ready_q <= ready_d;
      if (rd_state_q == RD_IDLE)
      begin
        dqs_q <= 1'b0;
      end
      else if (cnt_end & take & clk_run_q)
      begin
        dq_q <= rd_data;
        dqs_q <= ~dqs_q;
      end
    end
  end

  assign dq_o = dq_q;
  assign dq_oe = {`DQ_W{oe_q}};
  assign dqs_t_o = {`LANES{dqs_q}};
  assign dqs_c_o = {`LANES{~dqs_q}};
  assign dqs_oe = {`LANES{oe_q}};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ds_34r3_q <= 1'b0;
    end
    else
    begin
      ds_34r3_q <= ds_code == `DS_34R3;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  sequence s_ck_low;
    !s2_q.ck_t && s2_q.ck_c;
  endsequence

  sequence s_ck_rise;
    s_ck_low ##1 (s2_q.ck_t && !s2_q.ck_c);
  endsequence

  a_pos_edge_sample: assert property (
    @(posedge clk) disable iff (srst)
    s_ck_rise |=> (clk_run_q == $past(s2_q.cke)) && (cs_n_q == $past(s2_q.cs_n)))
    else $error("cke or chip select not taken on positive link edge");

  a_cmd_on_neg: assert property (
    @(posedge clk) disable iff (srst)
    (ck_neg && clk_run_q) |=> cmd_valid_q && (cmd_q.ca_fall == $past(s2_q.ca)))
    else $error("falling CA half not captured on negative edge");

  a_sdr_hold_neg: assert property (
    @(posedge clk) disable iff (srst)
    ck_neg |=> $stable(clk_run_q) && $stable(cs_n_q))
    else $error("single-rate input changed on negative edge");

  a_drivers_off: assert property (
    @(posedge clk) disable iff (srst)
    !clk_run_q |=> (dq_oe == '0) && (dqs_oe == '0))
    else $error("drivers on while clock enable low");

  a_pwr_entry: assert property (
    @(posedge clk) disable iff (srst)
    (ck_pos && clk_run_q && !s2_q.cke) |=> pwr_save_q ##1 pwr_save_q)
    else $error("power-saving entry missed");

  a_cmd_code: assert property (
    @(posedge clk) disable iff (srst)
    cmd_valid_q |-> (cmd_q.cke == clk_run_q) && (cmd_q.cs_n == cs_n_q))
    else $error("command code does not match sampled pins");

  a_col0_zero: assert property (
    @(posedge clk) disable iff (srst)
    cmd_valid_q |-> (addr_q.col[0] == 1'b0) && (addr_q.col[9:1] == cmd_q.ca_fall[9:1]))
    else $error("column bit 0 not zero");

  a_read_aligned: assert property (
    @(posedge clk) disable iff (srst)
    (rd_state_q != RD_IDLE && cnt_end && take && clk_run_q)
      |=> (dq_o == $past(rd_data)) && (dqs_t_o[0] != $past(dqs_t_o[0])))
    else $error("read data and strobe edge not launched together");

  a_lane1_byte: assert property (
    @(posedge clk) disable iff (srst)
    (wr_open && dqs_rise[1]) |=> byte_q[15:8] == $past(s2_q.dq[15:8]))
    else $error("lane 1 byte not timed by strobe pair 1");

  a_mask_discard: assert property (
    @(posedge clk) disable iff (srst)
    (wr_open && dqs_fall[3] && s2_q.dm[3]) |=> !keep_q[3] && wr_push_q)
    else $error("masked byte kept or beat not pushed");

  a_ds_select: assert property (
    @(posedge clk) disable iff (srst)
    (ds_code == `DS_34R3) [*2] |-> ds_34r3_q)
    else $error("drive-strength code not decoded");

endmodule : lpddr2_pin_if

// ==== test/host_ctrl_model.sv ====
// Behavioural host controller that drives the link pins of one x32 die.
// Assumes the bench resolves the shared data and strobe lines from all enables.
`timescale 1ns/1ps

module host_ctrl_model
  import lpddr2_pin_pkg::*;
(
  output logic ck_t, // Link clock, true.
  output logic ck_c, // Link clock, complement.
  output logic cke, // Clock enable.
  output logic cs_n, // Chip select, active low.
  output logic [`CA_W-1:0] ca, // Command/address.
  output logic [`DQ_W-1:0] dq, // Write data.
  output logic dq_drv, // Host drives data.
  output logic [`LANES-1:0] dqs, // Strobe, true side.
  output logic dqs_drv, // Host drives strobes.
  output logic [`LANES-1:0] dm // Write mask.
);
  // -----------------------------------------------------------------
  // Link clock
  // -----------------------------------------------------------------
  assign ck_c = ~ck_t;

  initial
  begin
    ck_t = 1'b0;
    cke = 1'b1;
    cs_n = 1'b1;
    ca = '0;
    dq = '0;
    dq_drv = 1'b0;
    dqs = '0;
    dqs_drv = 1'b0;
    dm = '0;
    #7;
    forever #(`LINK_HALF_NS) ck_t = ~ck_t;
  end

  // -----------------------------------------------------------------
  // Bus cycles
  // -----------------------------------------------------------------
  task send_cmd(input logic k, input logic s, input logic [`CA_W-1:0] x,
                input logic [`CA_W-1:0] y);
  begin
    @(posedge ck_t);
    #50;
    cke = k;
    cs_n = s;
    ca = x;
    @(posedge ck_t);
    #50;
    ca = y;
    @(negedge ck_t);
  end
  endtask : send_cmd

  task strobe_drive(input logic on);
  begin
    dqs = '0;
    dqs_drv = on;
    dq_drv = on;
  end
  endtask : strobe_drive

  task write_beat(input logic [`DQ_W-1:0] d, input logic [`LANES-1:0] m);
  begin
    dq = d;
    dm = m;
    #50;
    dqs = ~dqs;
    #50;
  end
  endtask : write_beat
endmodule : host_ctrl_model

// ==== test/tb.sv ====
// Self-checking bench for the device-side LPDDR2 pin logic.
// Assumes the host model drives the link and the bench plays the core side.
`timescale 1ns/1ps

module tb
  import lpddr2_pin_pkg::*;
;
  logic clk = 1'b0;
  logic srst, ck_t, ck_c, cke, cs_n, h_dq_drv, h_dqs_drv, cmd_valid_q;
  logic wr_en, wr_valid, wr_ready, wr_overflow_q, rd_en, rd_valid, rd_ready_q;
  logic clk_run_q, pwr_save_q, ds_34r3_q;
  logic rd_chk = 1'b0;
  logic [`CA_W-1:0] ca, rh, fh;
  logic [`DQ_W-1:0] h_dq, dq_w, dq_o, dq_oe, rd_data, rd_exp, r;
  logic [`LANES-1:0] h_dqs, dqs_t_w, dqs_c_w, dqs_t_o, dqs_c_o, dqs_oe, dm, m, dqs_prev;
  logic [`DS_W-1:0] ds_code;
  cmd_t cmd_q;
  addr_t addr_q;
  wr_beat_t wr_beat;
  cmd_t cq[$];
  addr_t aq[$];
  wr_beat_t wq[$];
  wr_beat_t we[$];
  int error_cnt = 0;
  int compares = 0;
  int rd_seen = 0;
  int seed, i, t;

  always #(`CLK_NS / 2.0) clk = ~clk;

  // Released lines show the inverse of the last driven value.
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & (h_dq_drv ? h_dq : ~h_dq));
  assign dqs_t_w = (dqs_oe & dqs_t_o) | (~dqs_oe & (h_dqs_drv ? h_dqs : ~h_dqs));
  assign dqs_c_w = (dqs_oe & dqs_c_o) | (~dqs_oe & (h_dqs_drv ? ~h_dqs : h_dqs));

  host_ctrl_model host_u (.ck_t(ck_t), .ck_c(ck_c), .cke(cke), .cs_n(cs_n), .ca(ca),
    .dq(h_dq), .dq_drv(h_dq_drv), .dqs(h_dqs), .dqs_drv(h_dqs_drv), .dm(dm));

  lpddr2_pin_if dut_u (.clk(clk), .srst(srst), .ck_t(ck_t), .ck_c(ck_c), .cke(cke),
    .cs_n(cs_n), .ca(ca), .dq_i(dq_w), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_t_i(dqs_t_w),
    .dqs_c_i(dqs_c_w), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o), .dqs_oe(dqs_oe), .dm(dm),
    .cmd_valid_q(cmd_valid_q), .cmd_q(cmd_q), .addr_q(addr_q), .clk_run_q(clk_run_q),
    .pwr_save_q(pwr_save_q), .wr_en(wr_en), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_beat(wr_beat), .wr_overflow_q(wr_overflow_q), .rd_en(rd_en),
    .rd_valid(rd_valid), .rd_ready_q(rd_ready_q), .rd_data(rd_data),
    .ds_code(ds_code), .ds_34r3_q(ds_34r3_q));

  // -----------------------------------------------------------------
  // Checking helpers
  // -----------------------------------------------------------------
  task cmp(input logic [31:0] g, input logic [31:0] e, input string s);
  begin
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %0t %s got %h exp %h", $time, s, g, e);
    end
  end
  endtask : cmp

  function automatic addr_t exp_addr(input logic [`CA_W-1:0] x, input logic [`CA_W-1:0] y);
    exp_addr = {x[9:7], y, x[6:3], y[9:1], 1'b0};
  endfunction : exp_addr

  function automatic logic [`DQ_W-1:0] lane_mask(input logic [`LANES-1:0] en);
    for (int k = 0; k < `LANES; k++)
      lane_mask[8*k +: 8] = {8{en[k]}};
  endfunction : lane_mask

  task send(input logic p, input logic k, input logic s, input logic [`CA_W-1:0] x,
            input logic [`CA_W-1:0] y, input int n);
  begin
    host_u.send_cmd(k, s, x, y);
    cq.delete();
    aq.delete();
    for (t = 0; t < 12 && cq.size() == 0; t++)
      @(posedge clk);
    @(negedge clk);
    cmp(cq.size(), n, "command count");
    if (n > 0)
    begin
      cmp({9'h0, cq[0]}, {9'h0, p, k, s, x, y}, "command");
      cmp({5'h0, aq[0]}, {5'h0, exp_addr(x, y)}, "address");
    end
  end
  endtask : send

  task test_done;
  begin
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask : test_done

  always @(posedge clk)
  begin
    if (cmd_valid_q === 1'b1)
    begin
      cq.push_back(cmd_q);
      aq.push_back(addr_q);
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      wq.push_back(wr_beat);
  end

  // Each taken read beat must appear on the pins one cycle later.
  always @(posedge clk)
  begin
    #2;
    if (rd_chk)
    begin
      rd_seen++;
      cmp(dq_o, rd_exp, "read data");
      cmp({28'h0, dqs_t_o}, {28'h0, ~dqs_prev}, "read strobe");
      cmp({28'h0, dqs_c_o}, {28'h0, ~dqs_t_o}, "strobe pair");
      cmp(dq_oe, 32'hffffffff, "data drive");
    end
    rd_chk = rd_ready_q & rd_valid;
    rd_exp = rd_data;
    dqs_prev = dqs_t_o;
  end

  initial
  begin
    #(`CLK_NS * 40000);
    error_cnt++;
    $display("wrong value %0t watchdog expired", $time);
    test_done();
  end

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  initial
  begin
    seed = 32'h6fd2;
    srst = 1'b1;
    wr_en = 1'b0;
    wr_ready = 1'b0;
    rd_en = 1'b0;
    rd_valid = 1'b0;
    rd_data = '0;
    ds_code = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    cmp({27'h0, dq_oe[0], dqs_oe}, 32'h0, "reset drive");
    cmp({30'h0, wr_valid, pwr_save_q}, 32'h0, "reset flags");
    srst = 1'b0;
    repeat (8) @(negedge clk);
    for (i = 0; i < 10; i++)
    begin
      r = $random(seed);
      rh = (i == 0) ? '1 : ((i == 1) ? '0 : r[9:0]);
      fh = (i == 0) ? '0 : ((i == 1) ? '1 : r[19:10]);
      send(1'b1, 1'b1, r[31], rh, fh, 1);
    end
    send(1'b1, 1'b0, 1'b0, 10'h155, 10'h2aa, 1);
    cmp({30'h0, pwr_save_q, clk_run_q}, 32'h2, "power save entry");
    send(1'b0, 1'b0, 1'b0, 10'h0ff, 10'h300, 0);
    rd_en = 1'b1;
    repeat (12) @(negedge clk);
    cmp({27'h0, dq_oe[0], dqs_oe}, 32'h0, "drive while stopped");
    rd_en = 1'b0;
    send(1'b0, 1'b1, 1'b1, 10'h2aa, 10'h155, 1);
    cmp({30'h0, pwr_save_q, clk_run_q}, 32'h1, "power save exit");
    for (i = 0; i < 16; i++)
    begin
      ds_code = i[3:0];
      @(negedge clk);
      cmp({31'h0, ds_34r3_q}, {31'h0, ds_code == `DS_34R3}, "drive strength");
    end
    host_u.strobe_drive(1'b1);
    repeat (8) @(negedge clk);
    wr_en = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < `FIFO_DEPTH + 1; i++)
    begin
      r = $random(seed);
      m = (i == 0) ? 4'h0 : ((i == 1) ? 4'hf : r[3:0]);
      r = $random(seed);
      host_u.write_beat(r, m);
      we.push_back({~m, r});
    end
    repeat (12) @(negedge clk);
    cmp({30'h0, wr_overflow_q, wr_valid}, 32'h3, "full fifo");
    wr_en = 1'b0;
    host_u.strobe_drive(1'b0);
    for (t = 0; t < 200 && wq.size() < `FIFO_DEPTH; t++)
    begin
      r = $random(seed);
      wr_ready = r[0];
      @(negedge clk);
    end
    wr_ready = 1'b0;
    repeat (2) @(negedge clk);
    cmp({31'h0, wr_valid}, 32'h0, "fifo empty");
    cmp(wq.size(), `FIFO_DEPTH, "beat count");
    for (i = 0; i < `FIFO_DEPTH; i++)
    begin
      cmp({28'h0, wq[i].byte_en}, {28'h0, we[i].byte_en}, "byte enable");
      cmp(wq[i].data & lane_mask(we[i].byte_en), we[i].data & lane_mask(we[i].byte_en),
          "lane data");
    end
    rd_data = $random(seed);
    rd_valid = 1'b1;
    rd_en = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      for (t = 0; t < 12 && rd_ready_q !== 1'b1; t++)
        @(negedge clk);
      cmp({31'h0, rd_ready_q}, 32'h1, "read ready");
      @(negedge clk);
      rd_data = $random(seed);
      if (i == 3)
      begin
        rd_valid = 1'b0;
        rd_en = 1'b0;
      end
      @(negedge clk);
    end
    repeat (10) @(negedge clk);
    cmp(rd_seen, 4, "read beats");
    cmp({27'h0, dq_oe[0], dqs_oe}, 32'h0, "read release");
    test_done();
  end
endmodule : tb
